/* core/sfc_regs.sv */
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
// Function
// - undervolt code picks minimum supply, zero disables
// - undervolt recovery bit: latch or auto-clear
// - overvolt code picks maximum supply, zero disables
// - overvolt recovery bit: latch or auto-clear
// - retry limit code, zero means unlimited
// - six hardware setup registers at fixed offsets
// - pin setup writable fields, rest read zero
// - speed source field picks command source
// - brake override: pin, force brake, none
// - tach output behaviour during a fault
// - auto retry after delay, latch past limit
module sfc_regs
  import sfc_pkg::*;
#(
  parameter int RETRY_CYC = RETRY_DELAY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // supply and pins
  input  wire logic [15:0] supply_mv_i,
  input  wire logic        lock_event_i,
  input  wire logic        brake_pin_i,
  input  wire logic        tach_raw_i,
  output logic             undervolt_fault_o,
  output logic             overvolt_fault_o,
  output logic             lock_fault_o,
  output logic             motor_run_ok_o,
  output logic             brake_o,
  output logic             tach_o,
  output sfc_speed_src_e   speed_src_o,
  output sfc_pin_s         pin_setup_o,
  output logic             irq_o
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [31:0] pin_ff;        // hw_pin_setup
  logic [31:0] dev_a_ff;      // device_setup_a
  logic [31:0] dev_b_ff;      // device_setup_b
  logic [31:0] peri_a_ff;     // peripheral_setup_a
  logic [31:0] gate_a_ff;     // gate_drive_setup_a
  logic [31:0] gate_b_ff;     // gate_drive_setup_b
  logic [31:0] supply_ff;     // supply_fault_setup
  logic [31:0] ctrl_ff;       // retry policy
  logic [2:0]  status_ff;     // sticky events
  logic [2:0]  mask_ff;       // interrupt mask
  logic        uv_ff;         // undervolt fault
  logic        ov_ff;         // overvolt fault
  logic        rt_latch_d_ff; // previous retry latch, edge detect
  logic        ack_ff;        // bus answer cycle
  logic [31:0] rdata_ff;      // read data
  logic        tach_ff;       // tach output
  logic        brake_ff;      // brake output

  sfc_supply_s sup;           // supply fields view
  sfc_pin_s    pin;           // pin fields view
  assign sup = sfc_supply_s'(supply_ff[10:0]);
  assign pin = sfc_pin_s'({pin_ff[27], pin_ff[10:6], pin_ff[3:0]});

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // byte enables to bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // merge write data into a register under byte and field masks
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] m;
    m     = be_mask(be) & wmask;
    merge = (old & ~m) | (wd & m);
  endfunction

  // undervolt limit in millivolts, zero means no limit
  function automatic logic [15:0] uv_limit_mv(input logic [2:0] sel);
    case (sel)
      3'h1:    uv_limit_mv = 16'h1194;  // 4.5 v
      3'h2:    uv_limit_mv = 16'h1388;  // 5 v
      3'h3:    uv_limit_mv = 16'h157c;  // 5.5 v
      3'h4:    uv_limit_mv = 16'h1770;  // 6 v
      3'h5:    uv_limit_mv = 16'h1d4c;  // 7.5 v
      3'h6:    uv_limit_mv = 16'h2710;  // 10 v
      3'h7:    uv_limit_mv = 16'h30d4;  // 12.5 v
      default: uv_limit_mv = 16'h0000;
    endcase
  endfunction

  // overvolt limit in millivolts, 20 v plus 2.5 v steps
  function automatic logic [15:0] ov_limit_mv(input logic [2:0] sel);
    case (sel)
      3'h1:    ov_limit_mv = 16'h4e20;  // 20 v
      3'h2:    ov_limit_mv = 16'h57e4;  // 22.5 v
      3'h3:    ov_limit_mv = 16'h61a8;  // 25 v
      3'h4:    ov_limit_mv = 16'h6b6c;  // 27.5 v
      3'h5:    ov_limit_mv = 16'h7530;  // 30 v
      3'h6:    ov_limit_mv = 16'h7ef4;  // 32.5 v
      3'h7:    ov_limit_mv = 16'h88b8;  // 35 v
      default: ov_limit_mv = 16'h0000;
    endcase
  endfunction

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  logic       req;      // read or write pending
  logic       wr_go;    // write takes effect this edge
  logic [7:0] idx;      // register index
  logic       clr_go;   // software clear of latched faults
  assign req   = avs_read_i | avs_write_i;
  assign idx   = avs_address_i[9:2];
  assign wr_go = avs_write_i & ack_ff;
  // one wait state: answer on the second cycle of each request
  assign avs_waitrequest_o = req & ~ack_ff;
  assign avs_readdata_o    = rdata_ff;
  assign clr_go = wr_go && (idx == IDX_CONTROL) && avs_byteenable_i[0]
                  && avs_writedata_i[CTRL_CLEAR_BIT];

  // answer cycle flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // ****************************************************************
  // read mux, sampled in the wait cycle
  // ****************************************************************
  logic [31:0] nxt_rdata;
  logic [4:0]  tries;        // retries used
  logic        rt_fault;     // retry controller fault
  logic        rt_latched;   // retries exhausted

  // address decode for reads
  always_comb begin
    nxt_rdata = 32'h0000_0000;  // unmapped reads as zero
    if (idx == IDX_PIN_SETUP) begin
      nxt_rdata = pin_ff;
    end else if (idx == IDX_DEV_A) begin
      nxt_rdata = dev_a_ff;
    end else if (idx == IDX_DEV_B) begin
      nxt_rdata = dev_b_ff;
    end else if (idx == IDX_PERI_A) begin
      nxt_rdata = peri_a_ff;
    end else if (idx == IDX_GATE_A) begin
      nxt_rdata = gate_a_ff;
    end else if (idx == IDX_GATE_B) begin
      nxt_rdata = gate_b_ff;
    end else if (idx == IDX_SUPPLY) begin
      nxt_rdata = supply_ff;
    end else if (idx == IDX_IRQ_STATUS) begin
      nxt_rdata = {29'h0, status_ff};
    end else if (idx == IDX_IRQ_MASK) begin
      nxt_rdata = {29'h0, mask_ff};
    end else if (idx == IDX_STATE) begin
      nxt_rdata = {19'h0, tries, 4'h0, rt_latched, rt_fault, ov_ff, uv_ff};
    end else if (idx == IDX_CONTROL) begin
      nxt_rdata = ctrl_ff;
    end
  end

  // read data register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= RST_ZERO;
    end else if (avs_read_i && !ack_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // configuration writes
  // ****************************************************************

  // pin setup: only documented fields take writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_ff <= RST_ZERO;
    end else if (wr_go && idx == IDX_PIN_SETUP) begin
      pin_ff <= merge(pin_ff, avs_writedata_i, avs_byteenable_i, PIN_WR_MASK);
    end
  end

  // remaining hardware setup words, held as plain storage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_a_ff  <= RST_ZERO;
      dev_b_ff  <= RST_ZERO;
      peri_a_ff <= RST_ZERO;
      gate_a_ff <= RST_ZERO;
      gate_b_ff <= RST_ZERO;
    end else if (wr_go) begin
      // fixed index per register
      if (idx == IDX_DEV_A) begin
        dev_a_ff <= merge(dev_a_ff, avs_writedata_i, avs_byteenable_i, '1);
      end else if (idx == IDX_DEV_B) begin
        dev_b_ff <= merge(dev_b_ff, avs_writedata_i, avs_byteenable_i, '1);
      end else if (idx == IDX_PERI_A) begin
        peri_a_ff <= merge(peri_a_ff, avs_writedata_i, avs_byteenable_i, '1);
      end else if (idx == IDX_GATE_A) begin
        gate_a_ff <= merge(gate_a_ff, avs_writedata_i, avs_byteenable_i, '1);
      end else if (idx == IDX_GATE_B) begin
        gate_b_ff <= merge(gate_b_ff, avs_writedata_i, avs_byteenable_i, '1);
      end
    end
  end

  // supply fault setup, control and mask
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      supply_ff <= RST_ZERO;
      ctrl_ff   <= RST_ZERO;
      mask_ff   <= 3'h0;
    end else if (wr_go) begin
      if (idx == IDX_SUPPLY) begin
        supply_ff <= merge(supply_ff, avs_writedata_i, avs_byteenable_i, SUPPLY_WR_MASK);
      end else if (idx == IDX_CONTROL) begin
        // clear bit is a strobe, never stored
        ctrl_ff <= merge(ctrl_ff, avs_writedata_i, avs_byteenable_i, CTRL_WR_MASK);
      end else if (idx == IDX_IRQ_MASK && avs_byteenable_i[0]) begin
        mask_ff <= avs_writedata_i[2:0] & EVT_MASK;
      end
    end
  end

  // ****************************************************************
  // supply monitor
  // ****************************************************************
  logic uv_now;  // supply below minimum
  logic ov_now;  // supply above maximum
  assign uv_now = (sup.undervolt_threshold_sel != 3'h0)
                  && (supply_mv_i < uv_limit_mv(sup.undervolt_threshold_sel));
  assign ov_now = (sup.overvolt_threshold_sel != 3'h0)
                  && (supply_mv_i > ov_limit_mv(sup.overvolt_threshold_sel));

  // undervolt fault: detection wins over any clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      uv_ff <= 1'b0;
    end else if (uv_now) begin
      uv_ff <= 1'b1;
    end else if (sup.undervolt_recovery_sel || clr_go) begin
      uv_ff <= 1'b0;
    end
  end

  // overvolt fault: same policy as undervolt
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ov_ff <= 1'b0;
    end else if (ov_now) begin
      ov_ff <= 1'b1;
    end else if (sup.overvolt_recovery_sel || clr_go) begin
      ov_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // retry handling for the lock fault
  // ****************************************************************
  sfc_retry_ctrl #(
    .DELAY_CYC (RETRY_CYC),
    .CNT_W     (24)
  ) u_retry (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .event_i     (lock_event_i),
    .auto_i      (ctrl_ff[CTRL_AUTO_BIT]),
    .limit_sel_i (sup.retry_limit_sel),
    .clear_i     (clr_go),
    .fault_o     (rt_fault),
    .latched_o   (rt_latched),
    .tries_o     (tries)
  );

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [2:0] evt;       // rising fault edges
  logic [2:0] w1c;       // bits software clears
  logic       uv_d_ff;   // previous undervolt
  logic       ov_d_ff;   // previous overvolt
  assign evt = {rt_latched & ~rt_latch_d_ff, ov_now & ~ov_d_ff, uv_now & ~uv_d_ff};
  assign w1c = (wr_go && idx == IDX_IRQ_STATUS && avs_byteenable_i[0]) ? avs_writedata_i[2:0] : 3'h0;

  // edge history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      uv_d_ff       <= 1'b0;
      ov_d_ff       <= 1'b0;
      rt_latch_d_ff <= 1'b0;
    end else begin
      uv_d_ff       <= uv_now;
      ov_d_ff       <= ov_now;
      rt_latch_d_ff <= rt_latched;
    end
  end

  // sticky status; a new event beats a same-cycle clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_ff <= 3'h0;
    end else begin
      status_ff <= (status_ff & ~w1c) | evt;
    end
  end

  assign irq_o = |(status_ff & mask_ff);

  // ****************************************************************
  // pin behaviour
  // ****************************************************************
  logic any_fault;  // any fault active
  assign any_fault = uv_ff | ov_ff | rt_fault;

  // brake output follows override field
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      brake_ff <= 1'b0;
    end else begin
      case (pin.brake_override)
        2'h1:    brake_ff <= 1'b1;         // force low-side brake
        2'h2:    brake_ff <= 1'b0;         // ignore pin
        default: brake_ff <= brake_pin_i;  // follow pin
      endcase
    end
  end

  // tach output; mode 3 during fault is undefined, treated as pass-through
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tach_ff <= 1'b0;
    end else if (!any_fault) begin
      tach_ff <= tach_raw_i;
    end else begin
      case (pin.tach_fault_behaviour)
        2'h0:    tach_ff <= tach_ff;     // hold last driving value
        2'h1:    tach_ff <= 1'b1;
        2'h2:    tach_ff <= 1'b0;
        default: tach_ff <= tach_raw_i;
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign undervolt_fault_o = uv_ff;
  assign overvolt_fault_o  = ov_ff;
  assign lock_fault_o      = rt_fault;
  assign motor_run_ok_o    = ~any_fault;
  assign brake_o           = brake_ff;
  assign tach_o            = tach_ff;
  assign speed_src_o       = sfc_speed_src_e'(pin.speed_source);
  assign pin_setup_o       = pin;

endmodule

/* core/sfc_pkg.sv */
// ****************************************************************
// supply fault config package
// ****************************************************************
package sfc_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_PIN_SETUP   = 8'ha4;  // hw_pin_setup
  localparam logic [7:0] IDX_DEV_A       = 8'ha6;  // device_setup_a
  localparam logic [7:0] IDX_DEV_B       = 8'ha8;  // device_setup_b
  localparam logic [7:0] IDX_PERI_A      = 8'haa;  // peripheral_setup_a
  localparam logic [7:0] IDX_GATE_A      = 8'hac;  // gate_drive_setup_a
  localparam logic [7:0] IDX_GATE_B      = 8'hae;  // gate_drive_setup_b
  localparam logic [7:0] IDX_SUPPLY      = 8'h90;  // supply_fault_setup
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'hb0;  // sticky events, write one to clear
  localparam logic [7:0] IDX_IRQ_MASK    = 8'hb2;  // interrupt enables
  localparam logic [7:0] IDX_STATE       = 8'hb4;  // live fault state, read only
  localparam logic [7:0] IDX_CONTROL     = 8'hb6;  // retry policy and fault clear

  // ****************************************************************
  // writable masks and reset values
  // ****************************************************************
  localparam logic [31:0] PIN_WR_MASK    = 32'h0800_07cf;
  localparam logic [31:0] SUPPLY_WR_MASK = 32'h0000_07ff;
  localparam logic [31:0] CTRL_WR_MASK   = 32'h0000_0001;
  localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
  localparam logic [2:0]  EVT_MASK       = 3'h7;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_AUTO_BIT   = 0;  // lock fault auto-retry policy
  localparam int CTRL_CLEAR_BIT  = 1;  // write one: clear latched faults
  localparam int EVT_UV          = 0;
  localparam int EVT_OV          = 1;
  localparam int EVT_RETRY_LATCH = 2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ          = 20_000_000;
  localparam int RETRY_DELAY_US  = 1000;
  localparam int RETRY_DELAY_CYC = RETRY_DELAY_US * (CLK_HZ / 1_000_000);

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    SFC_SPD_ANALOG,
    SFC_SPD_PWM,
    SFC_SPD_DIGITAL,
    SFC_SPD_FREQ
  } sfc_speed_src_e;

  // supply fault setup fields, bits 10..0
  typedef struct packed {
    logic [2:0] undervolt_threshold_sel;
    logic       undervolt_recovery_sel;
    logic [2:0] overvolt_threshold_sel;
    logic       overvolt_recovery_sel;
    logic [2:0] retry_limit_sel;
  } sfc_supply_s;

  // pin setup writable fields
  typedef struct packed {
    logic       bus_voltage_filter_off;
    logic [1:0] tach_idle_behaviour;
    logic [1:0] tach_fault_behaviour;
    logic       alarm_pin_en;
    logic [1:0] brake_override;
    logic [1:0] speed_source;
  } sfc_pin_s;

endpackage

/* core/sfc_retry_ctrl.sv */
`timescale 1ns/1ns
// ****************************************************************
// auto-retry controller for a recoverable fault
// ****************************************************************
module sfc_retry_ctrl
  import sfc_pkg::*;
#(
  parameter int DELAY_CYC = RETRY_DELAY_CYC,
  parameter int CNT_W     = 24
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       event_i,      // fault detected, one cycle
  input  wire logic       auto_i,       // auto-retry policy selected
  input  wire logic [2:0] limit_sel_i,  // retry_limit_sel
  input  wire logic       clear_i,      // software clear
  output logic            fault_o,      // fault active
  output logic            latched_o,    // retries exhausted
  output logic [4:0]      tries_o       // retries used
);

  typedef enum logic [1:0] {SFC_RT_IDLE, SFC_RT_WAIT, SFC_RT_LATCH} sfc_rt_e;

  sfc_rt_e            state_ff;    // controller state
  logic [CNT_W-1:0]   delay_ff;    // retry delay countdown
  logic [4:0]         tries_ff;    // retries taken so far

  // allowed attempts per code; zero means no limit
  function automatic logic [4:0] limit_of(input logic [2:0] sel);
    case (sel)
      3'h1:    limit_of = 5'h02;
      3'h2:    limit_of = 5'h03;
      3'h3:    limit_of = 5'h05;
      3'h4:    limit_of = 5'h07;
      3'h5:    limit_of = 5'h0a;
      3'h6:    limit_of = 5'h0f;
      3'h7:    limit_of = 5'h14;
      default: limit_of = 5'h00;
    endcase
  endfunction

  // one more retry allowed?
  logic room;
  assign room = (limit_sel_i == 3'h0) || (tries_ff < limit_of(limit_sel_i));

  // state and counters
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= SFC_RT_IDLE;
      delay_ff <= '0;
      tries_ff <= 5'h00;
    end else begin
      case (state_ff)
        SFC_RT_IDLE: begin
          if (event_i) begin
            if (auto_i && room) begin
              state_ff <= SFC_RT_WAIT;
              delay_ff <= CNT_W'(DELAY_CYC - 1);
              // saturate so unlimited mode never wraps
              if (tries_ff != 5'h1f) begin
                tries_ff <= tries_ff + 5'h01;
              end
            end else begin
              state_ff <= SFC_RT_LATCH;
            end
          end else if (clear_i) begin
            tries_ff <= 5'h00;
          end
        end
        SFC_RT_WAIT: begin
          // fault clears after the retry delay
          if (delay_ff == '0) begin
            state_ff <= SFC_RT_IDLE;
          end else begin
            delay_ff <= delay_ff - CNT_W'(1);
          end
        end
        default: begin
          // latched until software clears
          if (clear_i) begin
            state_ff <= SFC_RT_IDLE;
            tries_ff <= 5'h00;
          end
        end
      endcase
    end
  end

  assign fault_o   = (state_ff != SFC_RT_IDLE);
  assign latched_o = (state_ff == SFC_RT_LATCH);
  assign tries_o   = tries_ff;

endmodule

/* tb/sfc_regs_assertions.sv */
`timescale 1ns/1ns
// ****************************************************************
// port checker for the supply fault register block
// ****************************************************************
module sfc_regs_chk
  import sfc_pkg::*;
#(
  parameter int RETRY_CYC = RETRY_DELAY_CYC
) (
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire logic           avs_read_i,
  input wire logic           avs_waitrequest_o,
  input wire logic [15:0]    supply_mv_i,
  input wire logic           undervolt_fault_o,
  input wire logic           overvolt_fault_o,
  input wire logic           lock_fault_o,
  input wire logic           motor_run_ok_o,
  input wire logic           brake_o,
  input wire logic           tach_o,
  input wire sfc_speed_src_e speed_src_o,
  input wire sfc_pin_s       pin_setup_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // one wait state, never more
  a_wait_one: assert property (avs_read_i && avs_waitrequest_o ##1 avs_read_i |-> !avs_waitrequest_o)
    else $error("read kept waiting");
  a_fault_stop: assert property (undervolt_fault_o || overvolt_fault_o |-> !motor_run_ok_o)
    else $error("motor allowed during supply fault");
  a_uv_cause: assert property ($rose(undervolt_fault_o) |-> $past(supply_mv_i) < 16'h30d4)
    else $error("undervolt raised above every limit");
  a_ov_cause: assert property ($rose(overvolt_fault_o) |-> $past(supply_mv_i) > 16'h4e20)
    else $error("overvolt raised below every limit");
  // short retry delays still cover eight cycles
  a_retry_hold: assert property ($rose(lock_fault_o) |-> lock_fault_o [*8])
    else $error("lock fault dropped early");
  a_brake_force: assert property ($past(pin_setup_o.brake_override) == 2'h1 |-> brake_o)
    else $error("forced brake missing");
  a_brake_off: assert property ($past(pin_setup_o.brake_override) == 2'h2 |-> !brake_o)
    else $error("brake applied while overridden off");
  a_speed_src: assert property (speed_src_o == pin_setup_o.speed_source)
    else $error("speed source differs from field");
  a_tach_high: assert property ($past(pin_setup_o.tach_fault_behaviour) == 2'h1 && !$past(motor_run_ok_o) |-> tach_o)
    else $error("tach not held high in fault");
endmodule

bind sfc_regs sfc_regs_chk #(.RETRY_CYC(RETRY_CYC)) sfc_regs_chk_i (.*);

/* tb/testbench.sv */
`timescale 1ns/1ns
// ****************************************************************
// self-checking bench, register model kept in mdl
// ****************************************************************
module testbench;
  import sfc_pkg::*;
  logic           clk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic           lock_event_i = 1'b0, brake_pin_i = 1'b0, tach_raw_i = 1'b0;
  logic [9:0]     avs_address_i = 10'h0;
  logic [3:0]     avs_byteenable_i = 4'hf;
  logic [15:0]    supply_mv_i = 16'h3a98;  // inside every window
  logic [31:0]    avs_writedata_i = 32'h0, avs_readdata_o, rdv;
  logic [31:0]    mdl [256] = '{default: 32'h0};
  logic           avs_waitrequest_o, undervolt_fault_o, overvolt_fault_o, lock_fault_o;
  logic           motor_run_ok_o, brake_o, tach_o, irq_o;
  sfc_speed_src_e speed_src_o;
  sfc_pin_s       pin_setup_o;
  int             num_errors = 0, checks = 0;
  logic [7:0]     ids [8] = '{IDX_PIN_SETUP, IDX_DEV_A, IDX_DEV_B, IDX_PERI_A, IDX_GATE_A, IDX_GATE_B, IDX_SUPPLY, 8'ha5};
  logic [15:0]    uvl [7] = '{16'h1194, 16'h1388, 16'h157c, 16'h1770, 16'h1d4c, 16'h2710, 16'h30d4};
  logic [15:0]    ovl [7] = '{16'h4e20, 16'h57e4, 16'h61a8, 16'h6b6c, 16'h7530, 16'h7ef4, 16'h88b8};

  always #25 clk_i = ~clk_i;
  // short retry delay keeps the run brief
  sfc_regs #(.RETRY_CYC(8)) sfc_regs_i (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge; read data taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address_i <= {a, 2'h0};
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge clk_i); while (avs_waitrequest_o);
    rdv = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] wmask(input logic [7:0] a);
    if (a == IDX_PIN_SETUP) return PIN_WR_MASK;
    if (a == IDX_SUPPLY) return SUPPLY_WR_MASK;
    return (a inside {IDX_DEV_A, IDX_DEV_B, IDX_PERI_A, IDX_GATE_A, IDX_GATE_B}) ? 32'hffffffff : RST_ZERO;
  endfunction
  task automatic wrm(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    m = wmask(a) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    mdl[a] = (mdl[a] & ~m) | (d & m);
    bus(1'b1, a, d, be);
  endtask
  task automatic rdc(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rdv, mdl[a]);
  endtask
  // set one limit code with auto recovery, then move the supply
  task automatic vt(input logic ov, input int c, input logic [15:0] mv, input logic e);
    wrm(IDX_SUPPLY, ov ? (32'h88 | c << 4) : (32'h88 | c << 8), 4'hf);
    supply_mv_i <= mv;
    repeat (3) @(posedge clk_i);
    chk({31'h0, ov ? overvolt_fault_o : undervolt_fault_o}, {31'h0, e});
  endtask
  task automatic complete_run;
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    int k;
    void'($urandom(32'h2b2d));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ids[i]) rdc(ids[i]);
    $display("test reset done");
    repeat (24) begin
      k = $urandom % 7;  // unlisted index is only ever read
      wrm(ids[k], $urandom, 4'($urandom));
      rdc(ids[k]);
    end
    $display("test readback done");
    bus(1'b1, IDX_IRQ_MASK, 32'h0, 4'hf);
    for (int c = 1; c < 8; c++) begin
      vt(1'b0, c, uvl[c-1] - 16'h1, 1'b1);
      vt(1'b0, c, uvl[c-1], 1'b0);
      vt(1'b1, c, ovl[c-1] + 16'h1, 1'b1);
      vt(1'b1, c, ovl[c-1], 1'b0);
    end
    vt(1'b0, 0, 16'h0, 1'b0);
    vt(1'b1, 0, 16'hffff, 1'b0);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b1, IDX_IRQ_MASK, 32'h3, 4'hf);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, IDX_IRQ_STATUS, 32'h3, 4'hf);
    chk({31'h0, irq_o}, 32'h0);
    $display("test limits done");
    vt(1'b0, 7, 16'h0064, 1'b1);
    wrm(IDX_SUPPLY, 32'h700, 4'hf);
    supply_mv_i <= 16'h3a98;
    repeat (3) @(posedge clk_i);
    chk({31'h0, undervolt_fault_o}, 32'h1);
    for (int b = 0; b < 4; b++) begin
      brake_pin_i <= 1'($urandom);
      tach_raw_i <= 1'($urandom);
      wrm(IDX_PIN_SETUP, b * 32'h85, 4'hf);
      repeat (2) @(posedge clk_i);
      chk({30'h0, speed_src_o}, b);
      chk({31'h0, brake_o}, b == 1 ? 1 : b == 2 ? 0 : brake_pin_i);
      if (b != 0) chk({31'h0, tach_o}, b == 1 ? 1 : b == 2 ? 0 : tach_raw_i);
    end
    bus(1'b1, IDX_CONTROL, 32'h2, 4'hf);
    chk({31'h0, undervolt_fault_o}, 32'h0);
    $display("test latch and pins done");
    wrm(IDX_SUPPLY, 32'h1, 4'hf);
    bus(1'b1, IDX_CONTROL, 32'h1, 4'hf);
    for (int t = 0; t < 3; t++) begin
      lock_event_i <= 1'b1;
      @(posedge clk_i);
      lock_event_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({31'h0, lock_fault_o}, 32'h1);
      repeat (12) @(posedge clk_i);
      chk({31'h0, lock_fault_o}, {31'h0, t == 2});
    end
    bus(1'b0, IDX_STATE, 32'h0, 4'hf);
    chk(rdv & 32'h1f08, 32'h0208);
    bus(1'b0, IDX_IRQ_STATUS, 32'h0, 4'hf);
    chk(rdv, 32'h5);
    $display("test retry done");
    complete_run;
  end

  // hang guard, far beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    complete_run;
  end
endmodule
